// ### mpl_motion_limits.sv
`timescale 1ns/100ps
`include "mpl_params.svh"

// Functional notes
// - Enable bit clear forces one-step linear everywhere
// - Enable bit set honours profile bits
// - One exponential select bit per mode
// - Mode bit set selects exponential ramp
// - Mode bit clear uses bits 1, 2
// - Bit 1 picks one or two step
// - Bit 2 picks S-shaped ramp
// - Linear rate is feed over ramp one
// - First ramp time, default 100 ms
// - Two-step second rate fixed by settings
// - Rates switch at switching speed
// - Second ramp time, default 100 ms
// - S-curve keeps rate, rounds corners
// - Exponential uses time constant, bias speed
// - Speed capped at speed limit
// - One internal torque cap both directions
// - Internal torque cap always enforced
// - Cap clipped to motor maximum torque
// - Forward input active applies forward cap to forward torque
// - Reverse input active applies reverse cap to reverse torque
// - Status output shows torque limiting
// - Status low while torque request exceeds limit
module mpl_motion_limits (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic [3:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output logic      [31:0]        reg_rdata_o,
  input  wire mpl_pkg::mpl_mode_t op_mode_i,
  input  wire logic [31:0]        speed_req_i,
  input  wire logic [15:0]        torque_req_i,
  input  wire logic               torque_rev_i,
  input  wire logic               fwd_torque_limit_in_n_i,
  input  wire logic               rev_torque_limit_in_n_i,
  output mpl_pkg::mpl_prof_t      ramp_profile_o,
  output logic      [31:0]        target_speed_o,
  output logic      [15:0]        torque_cmd_o,
  output logic                    torque_limiting_out_n_o
);
  import mpl_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  mpl_state_t  st_reg;
  mpl_state_t  st_next;
  mpl_prof_t   prof_sel;
  logic        mode_exp;
  logic [15:0] int_cap;
  logic [15:0] dir_cap;
  logic [15:0] eff_cap;
  logic [31:0] spd_capped;
  logic [31:0] rd_mux;

  // ****************************************************************
  // Profile selection
  // ****************************************************************
  always_comb begin
    // Per-mode select bit
    // mode bit pick
    case (op_mode_i)
      MPL_MODE_AUTO:   mode_exp = st_reg.cfg.profile[`MPL_BIT_AUTO];
      MPL_MODE_MANUAL: mode_exp = st_reg.cfg.profile[`MPL_BIT_MANUAL];
      MPL_MODE_PULSE:  mode_exp = st_reg.cfg.profile[`MPL_BIT_PULSE];
      MPL_MODE_HOME:   mode_exp = st_reg.cfg.profile[`MPL_BIT_HOME];
      default:         mode_exp = 1'b0;
    endcase
    if (!st_reg.cfg.profile[`MPL_BIT_ENABLE]) begin
      prof_sel = MPL_PROF_LIN1;
    end else if (mode_exp) begin
      prof_sel = MPL_PROF_EXP;
    end else if (st_reg.cfg.profile[`MPL_BIT_SCURVE]) begin
      prof_sel = MPL_PROF_SCURV;
    end else if (st_reg.cfg.profile[`MPL_BIT_TWOSTEP]) begin
      prof_sel = MPL_PROF_LIN2;
    end else begin
      prof_sel = MPL_PROF_LIN1;
    end
  end

  // ****************************************************************
  // Speed and torque limits
  // ****************************************************************
  always_comb begin
    spd_capped = (speed_req_i > st_reg.cfg.spdcap) ? st_reg.cfg.spdcap : speed_req_i;
    int_cap = (st_reg.cfg.tqint > st_reg.cfg.motormax) ? st_reg.cfg.motormax
                                                       : st_reg.cfg.tqint;
    dir_cap = int_cap;
    if (!torque_rev_i && !fwd_torque_limit_in_n_i) begin
      dir_cap = st_reg.cfg.tqfwd;
    end
    if (torque_rev_i && !rev_torque_limit_in_n_i) begin
      dir_cap = st_reg.cfg.tqrev;
    end
    eff_cap = (dir_cap < int_cap) ? dir_cap : int_cap;
  end

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always_comb begin
    case (reg_addr_i)
      `MPL_ADDR_PROFILE:  rd_mux = {16'h0000, st_reg.cfg.profile};
      `MPL_ADDR_FEED:     rd_mux = st_reg.cfg.feed;
      `MPL_ADDR_RAMP1:    rd_mux = {16'h0000, st_reg.cfg.ramp1};
      `MPL_ADDR_RAMP2:    rd_mux = {16'h0000, st_reg.cfg.ramp2};
      `MPL_ADDR_SWITCH:   rd_mux = st_reg.cfg.switch_spd;
      `MPL_ADDR_SCURVE:   rd_mux = {16'h0000, st_reg.cfg.scurve};
      `MPL_ADDR_EXPTC:    rd_mux = {16'h0000, st_reg.cfg.exptc};
      `MPL_ADDR_BIAS:     rd_mux = st_reg.cfg.bias;
      `MPL_ADDR_SPDCAP:   rd_mux = st_reg.cfg.spdcap;
      `MPL_ADDR_TQINT:    rd_mux = {16'h0000, st_reg.cfg.tqint};
      `MPL_ADDR_TQFWD:    rd_mux = {16'h0000, st_reg.cfg.tqfwd};
      `MPL_ADDR_TQREV:    rd_mux = {16'h0000, st_reg.cfg.tqrev};
      `MPL_ADDR_MOTORMAX: rd_mux = {16'h0000, st_reg.cfg.motormax};
      `MPL_ADDR_STATUS:   rd_mux = {27'h0000000, st_reg.out.limiting, 1'b0, st_reg.out.prof};
      default:            rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // Ramp rate settings are stored for the ramp generator; feed change
    // does not rescale them, as both rates derive from stored times
    // settings
    if (reg_wr_i) begin
      case (reg_addr_i)
        `MPL_ADDR_PROFILE:  st_next.cfg.profile    = reg_wdata_i[15:0];
        `MPL_ADDR_FEED:     st_next.cfg.feed       = reg_wdata_i;
        `MPL_ADDR_RAMP1:    st_next.cfg.ramp1      = reg_wdata_i[15:0];
        `MPL_ADDR_RAMP2:    st_next.cfg.ramp2      = reg_wdata_i[15:0];
        `MPL_ADDR_SWITCH:   st_next.cfg.switch_spd = reg_wdata_i;
        `MPL_ADDR_SCURVE:   st_next.cfg.scurve     = reg_wdata_i[15:0];
        `MPL_ADDR_EXPTC:    st_next.cfg.exptc      = reg_wdata_i[15:0];
        `MPL_ADDR_BIAS:     st_next.cfg.bias       = reg_wdata_i;
        `MPL_ADDR_SPDCAP:   st_next.cfg.spdcap     = reg_wdata_i;
        `MPL_ADDR_TQINT:    st_next.cfg.tqint      = reg_wdata_i[15:0];
        `MPL_ADDR_TQFWD:    st_next.cfg.tqfwd      = reg_wdata_i[15:0];
        `MPL_ADDR_TQREV:    st_next.cfg.tqrev      = reg_wdata_i[15:0];
        `MPL_ADDR_MOTORMAX: st_next.cfg.motormax   = reg_wdata_i[15:0];
        default: begin
        end
      endcase
    end
    st_next.out.rdata      = reg_rd_i ? rd_mux : 32'h0000_0000;
    st_next.out.prof       = prof_sel;
    st_next.out.target_spd = spd_capped;
    st_next.out.torque_cmd = (torque_req_i > eff_cap) ? eff_cap : torque_req_i;
    st_next.out.limiting   = (torque_req_i > eff_cap);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg.cfg.profile    <= `MPL_RST_PROFILE;
      st_reg.cfg.feed       <= `MPL_RST_FEED;
      st_reg.cfg.ramp1      <= `MPL_RST_RAMP;
      st_reg.cfg.ramp2      <= `MPL_RST_RAMP;
      st_reg.cfg.switch_spd <= `MPL_RST_SWITCH;
      st_reg.cfg.scurve     <= `MPL_RST_SCURVE;
      st_reg.cfg.exptc      <= `MPL_RST_EXPTC;
      st_reg.cfg.bias       <= `MPL_RST_BIAS;
      st_reg.cfg.spdcap     <= `MPL_RST_SPDCAP;
      st_reg.cfg.tqint      <= `MPL_RST_TQ;
      st_reg.cfg.tqfwd      <= `MPL_RST_TQ;
      st_reg.cfg.tqrev      <= `MPL_RST_TQ;
      st_reg.cfg.motormax   <= `MPL_RST_MOTORMAX;
      st_reg.out            <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_o             = st_reg.out.rdata;
  assign ramp_profile_o          = st_reg.out.prof;
  assign target_speed_o          = st_reg.out.target_spd;
  assign torque_cmd_o            = st_reg.out.torque_cmd;
  assign torque_limiting_out_n_o = ~st_reg.out.limiting;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_DISABLED_LIN1: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !st_reg.cfg.profile[0]) |=> ramp_profile_o == MPL_PROF_LIN1)
    else $error("profile not linear while disabled");
  AST_EXP_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st_reg.cfg.profile[0] && mode_exp) |=> ramp_profile_o == MPL_PROF_EXP)
    else $error("exponential not selected");
  AST_SCURVE_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st_reg.cfg.profile[0] && !mode_exp && st_reg.cfg.profile[2])
    |=> ramp_profile_o == MPL_PROF_SCURV)
    else $error("S-shaped not selected");
  AST_TWOSTEP_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st_reg.cfg.profile[2:0] == 3'h3 && !mode_exp) |=> ramp_profile_o == MPL_PROF_LIN2)
    else $error("two-step not selected");
  AST_SPEED_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> target_speed_o <= $past(st_reg.cfg.spdcap))
    else $error("speed exceeds cap");
  AST_INT_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> torque_cmd_o <= $past(st_reg.cfg.motormax) && torque_cmd_o <= $past(st_reg.cfg.tqint))
    else $error("torque exceeds internal cap");
  AST_FWD_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !torque_rev_i && !fwd_torque_limit_in_n_i)
    |=> torque_cmd_o <= $past(st_reg.cfg.tqfwd))
    else $error("forward external cap ignored");
  AST_REV_CAP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && torque_rev_i && !rev_torque_limit_in_n_i)
    |=> torque_cmd_o <= $past(st_reg.cfg.tqrev))
    else $error("reverse external cap ignored");
  AST_STATUS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> torque_limiting_out_n_o == !($past(torque_req_i) > torque_cmd_o))
    else $error("limiting status mismatch");

  // ****************************************************************
  // Profile, limit and setting checks
  // ****************************************************************
  // enabled bits honoured
  AST_ENABLE_HONOUR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st_reg.cfg.profile[0] && (mode_exp || st_reg.cfg.profile[2:1] != 2'b00))
    |=> ramp_profile_o != MPL_PROF_LIN1)
    else $error("enabled profile bits ignored");
  AST_MODE_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_exp == st_reg.cfg.profile[`MPL_BIT_AUTO + 2 * int'(op_mode_i)])
    else $error("mode select bit mismatch");
  AST_ONESTEP_SEL: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && st_reg.cfg.profile[2:0] == 3'h1 && !mode_exp) |=> ramp_profile_o == MPL_PROF_LIN1)
    else $error("one-step not selected");
  AST_SPEED_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && speed_req_i <= st_reg.cfg.spdcap) |=> target_speed_o == $past(speed_req_i))
    else $error("speed altered below cap");
  AST_SPEED_CLIP: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && speed_req_i > st_reg.cfg.spdcap) |=> target_speed_o == $past(st_reg.cfg.spdcap))
    else $error("speed not clipped to cap");
  AST_INT_REV: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && torque_rev_i && rev_torque_limit_in_n_i && torque_req_i > int_cap)
    |=> torque_cmd_o == $past(int_cap))
    else $error("reverse internal cap not applied");
  AST_INT_FWD: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !torque_rev_i && fwd_torque_limit_in_n_i && torque_req_i > int_cap)
    |=> torque_cmd_o == $past(int_cap))
    else $error("forward internal cap not applied");
  AST_FWD_EXACT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !torque_rev_i && !fwd_torque_limit_in_n_i && st_reg.cfg.tqfwd < int_cap
     && torque_req_i > st_reg.cfg.tqfwd) |=> torque_cmd_o == $past(st_reg.cfg.tqfwd))
    else $error("forward external cap not exact");
  AST_REV_EXACT: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && torque_rev_i && !rev_torque_limit_in_n_i && st_reg.cfg.tqrev < int_cap
     && torque_req_i > st_reg.cfg.tqrev) |=> torque_cmd_o == $past(st_reg.cfg.tqrev))
    else $error("reverse external cap not exact");
  AST_MIN_FWD: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !torque_rev_i && !fwd_torque_limit_in_n_i && st_reg.cfg.tqfwd > int_cap
     && torque_req_i > int_cap) |=> torque_cmd_o == $past(int_cap))
    else $error("larger forward cap raised limit");
  AST_STATUS_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> torque_limiting_out_n_o == (torque_cmd_o == $past(torque_req_i)))
    else $error("status disagrees with command");
  AST_STATUS_READ: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_rd_i && reg_addr_i == `MPL_ADDR_STATUS)
    |=> reg_rdata_o[4] == !$past(torque_limiting_out_n_o)
        && reg_rdata_o[2:0] == $past(ramp_profile_o))
    else $error("status word mismatch");
  AST_FEED_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_FEED)
    |=> st_reg.cfg.feed == $past(reg_wdata_i))
    else $error("feed speed not stored");
  AST_RAMP1_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_RAMP1)
    |=> st_reg.cfg.ramp1 == $past(reg_wdata_i[15:0]))
    else $error("first ramp time not stored");
  AST_FEED_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_FEED)
    |=> $stable(st_reg.cfg.ramp1) && $stable(st_reg.cfg.ramp2)
        && $stable(st_reg.cfg.switch_spd))
    else $error("feed write disturbed ramp settings");
  AST_SWITCH_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_SWITCH)
    |=> st_reg.cfg.switch_spd == $past(reg_wdata_i))
    else $error("switching speed not stored");
  AST_RAMP2_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_RAMP2)
    |=> st_reg.cfg.ramp2 == $past(reg_wdata_i[15:0]))
    else $error("second ramp time not stored");
  AST_SCURVE_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_SCURVE)
    |=> st_reg.cfg.scurve == $past(reg_wdata_i[15:0]))
    else $error("S-curve time not stored");
  AST_EXPTC_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_EXPTC)
    |=> st_reg.cfg.exptc == $past(reg_wdata_i[15:0]))
    else $error("time constant not stored");
  AST_BIAS_WR: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && reg_wr_i && reg_addr_i == `MPL_ADDR_BIAS)
    |=> st_reg.cfg.bias == $past(reg_wdata_i))
    else $error("bias speed not stored");

  COV_EXP: cover property (@(posedge clk_i) disable iff (rst_i) ramp_profile_o == MPL_PROF_EXP);
  COV_SCURV: cover property (@(posedge clk_i) disable iff (rst_i)
    ramp_profile_o == MPL_PROF_SCURV);
  COV_LIMIT: cover property (@(posedge clk_i) disable iff (rst_i) !torque_limiting_out_n_o);
  COV_FWD: cover property (@(posedge clk_i) disable iff (rst_i)
    !fwd_torque_limit_in_n_i && !torque_limiting_out_n_o);
  COV_REV: cover property (@(posedge clk_i) disable iff (rst_i)
    torque_rev_i && !rev_torque_limit_in_n_i && !torque_limiting_out_n_o);

endmodule : mpl_motion_limits

// ### mpl_params.svh
`ifndef MPL_PARAMS_SVH
`define MPL_PARAMS_SVH

// Register indices on the plain register port
`define MPL_ADDR_PROFILE   4'h0
`define MPL_ADDR_FEED      4'h1
`define MPL_ADDR_RAMP1     4'h2
`define MPL_ADDR_RAMP2     4'h3
`define MPL_ADDR_SWITCH    4'h4
`define MPL_ADDR_SCURVE    4'h5
`define MPL_ADDR_EXPTC     4'h6
`define MPL_ADDR_BIAS      4'h7
`define MPL_ADDR_SPDCAP    4'h8
`define MPL_ADDR_TQINT     4'h9
`define MPL_ADDR_TQFWD     4'ha
`define MPL_ADDR_TQREV     4'hb
`define MPL_ADDR_MOTORMAX  4'hc
`define MPL_ADDR_STATUS    4'hd

// Profile configuration bit positions
`define MPL_BIT_ENABLE     0
`define MPL_BIT_TWOSTEP    1
`define MPL_BIT_SCURVE     2
`define MPL_BIT_AUTO       8
`define MPL_BIT_MANUAL     10
`define MPL_BIT_PULSE      12
`define MPL_BIT_HOME       14

// Reset values
`define MPL_RST_PROFILE    16'h0000
`define MPL_RST_FEED       32'h0000_01f4
`define MPL_RST_RAMP       16'h0064
`define MPL_RST_SWITCH     32'h0000_01f4
`define MPL_RST_SCURVE     16'h0000
`define MPL_RST_EXPTC      16'h0064
`define MPL_RST_BIAS       32'h0000_0000
`define MPL_RST_SPDCAP     32'h0000_2710
`define MPL_RST_TQ         16'h0320
`define MPL_RST_MOTORMAX   16'h0320

`endif

// ### mpl_pkg.sv
package mpl_pkg;

  typedef enum logic [1:0] {
    MPL_MODE_AUTO   = 2'b00,
    MPL_MODE_MANUAL = 2'b01,
    MPL_MODE_PULSE  = 2'b10,
    MPL_MODE_HOME   = 2'b11
  } mpl_mode_t;

  typedef enum logic [2:0] {
    MPL_PROF_LIN1  = 3'b000,
    MPL_PROF_LIN2  = 3'b001,
    MPL_PROF_SCURV = 3'b010,
    MPL_PROF_EXP   = 3'b011
  } mpl_prof_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mpl_bus_req_t;

  typedef struct packed {
    logic [15:0] profile;
    logic [31:0] feed;
    logic [15:0] ramp1;
    logic [15:0] ramp2;
    logic [31:0] switch_spd;
    logic [15:0] scurve;
    logic [15:0] exptc;
    logic [31:0] bias;
    logic [31:0] spdcap;
    logic [15:0] tqint;
    logic [15:0] tqfwd;
    logic [15:0] tqrev;
    logic [15:0] motormax;
  } mpl_cfg_t;

  typedef struct packed {
    mpl_prof_t   prof;
    logic [31:0] target_spd;
    logic [15:0] torque_cmd;
    logic        limiting;
    logic [31:0] rdata;
  } mpl_out_t;

  typedef struct packed {
    mpl_cfg_t cfg;
    mpl_out_t out;
  } mpl_state_t;

endpackage : mpl_pkg

// ### mpl_host_model.sv
`timescale 1ns/100ps
// ****************************************
// Host side of the limit contacts
// ****************************************
module mpl_host_model (
  input  wire logic fwd_on_i,
  input  wire logic rev_on_i,
  output logic      fwd_torque_limit_in_n_o,
  output logic      rev_torque_limit_in_n_o
);
  assign fwd_torque_limit_in_n_o = ~fwd_on_i;
  assign rev_torque_limit_in_n_o = ~rev_on_i;
endmodule : mpl_host_model

// ### mpl_motion_limits_tb.sv
`timescale 1ns/100ps
`include "mpl_params.svh"
module mpl_motion_limits_tb;
  import mpl_pkg::*;
  logic        clk_i, rst_i, ce_i, wr, rd, rd_seen, rev, fwd_on, rev_on;
  logic        fwd_n, rev_n, lim_n;
  logic [3:0]  addr;
  logic [31:0] wdata, rdata, spd_req, spd, d, s;
  logic [15:0] tq_req, tq, c, ti, tf, tr, tm;
  logic [16:0] ex;
  mpl_mode_t   mode;
  mpl_prof_t   prof;
  logic [31:0] q [$];
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;
  // Sixteen-bit registers read back with zero upper half
  localparam logic [12:0] W16 = 13'h1e6d;
  logic [31:0] dflt [13] = '{32'(`MPL_RST_PROFILE), `MPL_RST_FEED, 32'(`MPL_RST_RAMP),
    32'(`MPL_RST_RAMP), `MPL_RST_SWITCH, 32'(`MPL_RST_SCURVE), 32'(`MPL_RST_EXPTC),
    `MPL_RST_BIAS, `MPL_RST_SPDCAP, 32'(`MPL_RST_TQ), 32'(`MPL_RST_TQ), 32'(`MPL_RST_TQ),
    32'(`MPL_RST_MOTORMAX)};

  mpl_motion_limits dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .op_mode_i(mode), .speed_req_i(spd_req), .torque_req_i(tq_req), .torque_rev_i(rev),
    .fwd_torque_limit_in_n_i(fwd_n), .rev_torque_limit_in_n_i(rev_n),
    .ramp_profile_o(prof), .target_speed_o(spd), .torque_cmd_o(tq),
    .torque_limiting_out_n_o(lim_n));
  mpl_host_model host (.fwd_on_i(fwd_on), .rev_on_i(rev_on),
    .fwd_torque_limit_in_n_o(fwd_n), .rev_torque_limit_in_n_o(rev_n));

  // ****************************************
  // Tasks and models
  // ****************************************
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task print_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    q.push_back(v);
    @(posedge clk_i);
    rd <= 1'b0;
  endtask : rd_reg

  function automatic mpl_prof_t pr_exp(logic [15:0] cf, mpl_mode_t m);
    if (!cf[0]) return MPL_PROF_LIN1;
    if (cf[8 + 2 * int'(m)]) return MPL_PROF_EXP;
    if (cf[2]) return MPL_PROF_SCURV;
    return cf[1] ? MPL_PROF_LIN2 : MPL_PROF_LIN1;
  endfunction : pr_exp

  // Internal cap clipped, then the active direction's external cap if smaller
  function automatic logic [16:0] tq_exp(logic [15:0] t, i, f, r, m, logic rv, fo, ro);
    logic [15:0] cap;
    cap = (i > m) ? m : i;
    if (!rv && fo && f < cap) cap = f;
    if (rv && ro && r < cap) cap = r;
    return (t > cap) ? {1'b0, cap} : {1'b1, t};
  endfunction : tq_exp

  // ****************************************
  // Clock, monitor, watchdog, stimulus
  // ****************************************
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) rd_seen <= rd & ce_i;

  // Read data stands only in the cycle after the strobe
  always @(negedge clk_i) begin
    if (rd_seen) check(rdata, q.pop_front());
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    rst_i = 1'b1; ce_i = 1'b1; wr = 1'b0; rd = 1'b0; addr = 4'h0;
    wdata = 32'h0; mode = MPL_MODE_AUTO; spd_req = 32'h0; tq_req = 16'h0;
    rev = 1'b0; fwd_on = 1'b0; rev_on = 1'b0;
    void'($urandom(32'h54ea));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 13; a++) rd_reg(4'(a), dflt[a]);
    $display("reset values done");
    for (int a = 0; a < 16; a++) begin
      if (a == 13) continue;
      d = $urandom;
      wr_reg(4'(a), d);
      rd_reg(4'(a), a > 12 ? 32'h0 : (W16[a] ? {16'h0, d[15:0]} : d));
    end
    wr_reg(`MPL_ADDR_TQINT, 32'h11);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr_reg(`MPL_ADDR_TQINT, 32'h22);
    ce_i <= 1'b1;
    rd_reg(`MPL_ADDR_TQINT, 32'h11);
    $display("register access done");
    for (int k = 0; k < 40; k++) begin
      c = 16'($urandom) & 16'h5507;
      wr_reg(`MPL_ADDR_PROFILE, {16'h0, c});
      @(posedge clk_i);
      mode <= mpl_mode_t'(2'($urandom));
      @(posedge clk_i);
      #1;
      check(32'(prof), 32'(pr_exp(c, mode)));
    end
    $display("profile select done");
    wr_reg(`MPL_ADDR_SPDCAP, 32'h2710);
    for (int k = 0; k < 10; k++) begin
      s = (k == 0) ? 32'h2710 : $urandom_range(0, 32'h4e20);
      @(posedge clk_i);
      spd_req <= s;
      @(posedge clk_i);
      #1;
      check(spd, (s > 32'h2710) ? 32'h2710 : s);
    end
    $display("speed cap done");
    for (int k = 0; k < 6; k++) begin
      ti = 16'($urandom_range(0, 900));
      tf = 16'($urandom_range(0, 800));
      tr = 16'($urandom_range(0, 800));
      tm = 16'($urandom_range(100, 800));
      wr_reg(`MPL_ADDR_TQINT, {16'h0, ti});
      wr_reg(`MPL_ADDR_TQFWD, {16'h0, tf});
      wr_reg(`MPL_ADDR_TQREV, {16'h0, tr});
      wr_reg(`MPL_ADDR_MOTORMAX, {16'h0, tm});
      for (int j = 0; j < 8; j++) begin
        @(posedge clk_i);
        tq_req <= 16'($urandom_range(0, 1000));
        rev    <= 1'($urandom);
        fwd_on <= 1'($urandom);
        rev_on <= 1'($urandom);
        @(posedge clk_i);
        #1;
        ex = tq_exp(tq_req, ti, tf, tr, tm, rev, fwd_on, rev_on);
        check({15'h0, lim_n, tq}, {15'h0, ex});
      end
    end
    $display("torque limits done");
    // Inputs still stand from the last torque step, so the flag has not moved
    rd_reg(`MPL_ADDR_STATUS, {27'h0, ~ex[16], 1'b0, 3'(pr_exp(c, mode))});
    repeat (2) @(posedge clk_i);
    print_verdict();
  end
endmodule : mpl_motion_limits_tb
